// [core/iobfi_pkg.sv]
package iobfi_pkg;

   // widths
   localparam int EA_W = 32;
   localparam int DATA_W = 32;
   localparam int RADDR_W = 4;
   localparam int NBUF = 16;
   localparam int BUF_W = 4;
   localparam int ST_W = 4;
   localparam int CTRL_W = 2;

   // software register offsets (byte addresses)
   localparam logic [RADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [RADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [RADDR_W-1:0] REG_MASK = 4'h8;
   localparam logic [RADDR_W-1:0] REG_BUFST = 4'hc;

   // control register fields and reset value
   localparam int CTRL_BUFFERED = 0;
   localparam int CTRL_DUAL = 1;
   localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

   // status / mask fields and reset values
   localparam int ST_REJECT = 0;
   localparam int ST_DSI = 1;
   localparam int ST_FLUSH = 2;
   localparam int ST_NEXTALL = 3;
   localparam logic [ST_W-1:0] STATUS_RST = 4'h0;
   localparam logic [ST_W-1:0] MASK_RST = 4'h0;

   // effective address fields, bit 0 is the lsb of the address
   localparam int EA_BUF_HI = 19;
   localparam int EA_BUF_LO = 16;
   localparam int EA_OP_HI = 7;
   localparam int EA_OP_LO = 0;
   localparam logic [7:0] CMD_FLUSH = 8'h01;
   localparam logic [7:0] CMD_INVAL = 8'h02;
   localparam logic [7:0] CMD_NEXT = 8'h03;

   // buffer control word 8 layout
   localparam int BCR8_D = 31;
   localparam int BCR8_B = 30;
   localparam int BCR8_I = 29;
   localparam int BCR8_N = 28;
   localparam logic [DATA_W-1:0] INVAL_DATA = 32'h2000_0000;

   // per-buffer flag reset values
   localparam logic [NBUF-1:0] FLAGS_RST = 16'h0000;
   localparam logic [NBUF-1:0] INVAL_RST = 16'hffff;

   typedef enum logic {
      IOBFI_IDLE = 1'b0,
      IOBFI_WB = 1'b1
   } iobfi_state_t;

endpackage

// [core/iobfi_core.sv]
// Summary of operation
// - flush is a store; address bits 16..19 select the channel buffer
// - flush writes the buffer back to memory only when it is dirty
// - while write-back runs the block is busy and takes no command
// - after flush clear dirty, busy and next flags, set invalidate flag
// - buffered: flush store data ignored, flush load raises storage interrupt
// - unbuffered: flush store is nop, load returns zeroes without interrupt
// - invalidate forces refetch; bus-master ops also reload control word 4
// - invalidate load returns buffer state bits and changes nothing
// - unbuffered: invalidate store is nop, load returns zeroes
// - privilege key one rejects command, interrupt, invalid-op status
// - next-buffer invalidate clears the next flag, dropping prefetched data
// - prefetch ahead of a bus master only with dual buffering
// - next invalidate is full-word store of zero; load raises interrupt
// - next invalidate interrupts when unbuffered or without dual buffers
// - buffered dual: on internal error drop next buffers of all 16
`timescale 1ns/100ps
module iobfi_core (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // processor command port
   input wire logic cmd_valid,
   input wire logic cmd_store,
   input wire logic [iobfi_pkg::EA_W-1:0] cmd_ea,
   input wire logic [iobfi_pkg::DATA_W-1:0] cmd_wdata,
   input wire logic cmd_priv_key,
   input wire logic next_err,
   output logic busy_ff,
   output logic rsp_valid_ff,
   output logic rsp_dsi_ff,
   output logic [iobfi_pkg::DATA_W-1:0] rsp_rdata_ff,
   output logic inv_op_ff,
   // memory write-back port
   output logic wb_req_ff,
   output logic [iobfi_pkg::BUF_W-1:0] wb_idx_ff,
   input wire logic wb_done,
   // buffer events from the data path
   input wire logic fill_valid,
   input wire logic fill_dirty,
   input wire logic [iobfi_pkg::BUF_W-1:0] fill_idx,
   input wire logic prefetch_valid,
   input wire logic [iobfi_pkg::BUF_W-1:0] prefetch_idx,
   input wire logic op_start,
   input wire logic op_is_bm,
   input wire logic [iobfi_pkg::BUF_W-1:0] op_idx,
   output logic refetch_ff,
   output logic reload_bcr4_ff,
   output logic [iobfi_pkg::BUF_W-1:0] refetch_idx_ff,
   output logic [iobfi_pkg::NBUF-1:0] next_flags_ff,
   // software register port
   input wire logic [iobfi_pkg::RADDR_W-1:0] reg_addr,
   input wire logic [iobfi_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [iobfi_pkg::DATA_W-1:0] reg_rdata_ff,
   // interrupt
   output logic irq_ff
);
   import iobfi_pkg::*;

   // one-hot select of a buffer number
   function automatic logic [NBUF-1:0] onehot(input logic [BUF_W-1:0] idx);
      logic [NBUF-1:0] m;
      m = '0;
      m[idx] = 1'b1;
      return m;
   endfunction

   // control word 8 image of one buffer
   function automatic logic [DATA_W-1:0] buf_word(
      input logic d, input logic b, input logic i, input logic n);
      logic [DATA_W-1:0] w;
      w = '0;
      w[BCR8_D] = d;
      w[BCR8_B] = b;
      w[BCR8_I] = i;
      w[BCR8_N] = n;
      return w;
   endfunction

   iobfi_state_t state_ff, nxt_state;
   logic [NBUF-1:0] d_ff, b_ff, i_ff;
   logic [NBUF-1:0] nxt_d, nxt_b, nxt_i, nxt_n;
   logic [CTRL_W-1:0] ctrl_ff;
   logic [ST_W-1:0] status_ff, mask_ff, nxt_status;

   // command decode
   wire cmd_go = cmd_valid && !busy_ff;
   wire [BUF_W-1:0] cmd_buf = cmd_ea[EA_BUF_HI:EA_BUF_LO];
   wire [7:0] cmd_op = cmd_ea[EA_OP_HI:EA_OP_LO];
   wire is_flush = (cmd_op == CMD_FLUSH);
   wire is_inval = (cmd_op == CMD_INVAL);
   wire is_next = (cmd_op == CMD_NEXT);
   wire is_ours = is_flush || is_inval || is_next;
   wire buffered = ctrl_ff[CTRL_BUFFERED];
   wire dual = ctrl_ff[CTRL_DUAL];

   // privilege gate sits in front of every action
   wire priv_bad = cmd_go && is_ours && cmd_priv_key;
   wire ok = cmd_go && is_ours && !cmd_priv_key;

   // flush: store data is never looked at
   wire flush_st = ok && is_flush && cmd_store && buffered;
   wire flush_dirty = flush_st && d_ff[cmd_buf];
   wire flush_now = flush_st && !d_ff[cmd_buf];
   wire flush_ld = ok && is_flush && !cmd_store && buffered;
   wire wb_finish = (state_ff == IOBFI_WB) && wb_done;

   // invalidate: data is assumed to be the invalidate-only word
   wire inval_st = ok && is_inval && cmd_store && buffered;
   wire inval_ld = ok && is_inval && !cmd_store && buffered;

   // next-buffer invalidate
   wire next_ok = ok && is_next && cmd_store && buffered && dual;
   wire next_all = next_ok && next_err;
   wire next_bad = ok && is_next && (!cmd_store || !buffered || !dual);

   // storage interrupt causes
   wire dsi_cmd = priv_bad || flush_ld || next_bad;

   // answer now, or when write-back ends
   wire rsp_now = (cmd_go && is_ours && !flush_dirty) || wb_finish;

   // load data: only a buffered invalidate load returns state
   wire [DATA_W-1:0] load_word = inval_ld ?
      buf_word(d_ff[cmd_buf], b_ff[cmd_buf], i_ff[cmd_buf],
               next_flags_ff[cmd_buf]) : '0;

   // flag masks
   wire [BUF_W-1:0] clr_idx = wb_finish ? wb_idx_ff : cmd_buf;
   wire [NBUF-1:0] flush_m =
      (wb_finish || flush_now) ? onehot(clr_idx) : '0;
   wire [NBUF-1:0] inval_m = inval_st ? onehot(cmd_buf) : '0;
   wire [NBUF-1:0] next_m =
      (next_ok && !next_err) ? onehot(cmd_buf) : '0;
   wire [NBUF-1:0] fill_m = fill_valid ? onehot(fill_idx) : '0;
   wire [NBUF-1:0] dirty_m = (fill_valid && fill_dirty) ?
      onehot(fill_idx) : '0;
   // read-ahead only exists with the dual option
   wire pref_ok = prefetch_valid && buffered && dual;
   wire [NBUF-1:0] pref_m = pref_ok ? onehot(prefetch_idx) : '0;
   wire op_refetch = op_start && i_ff[op_idx];
   wire [NBUF-1:0] op_m = op_refetch ? onehot(op_idx) : '0;

   // register port decode
   wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
   wire wr_status = reg_wr && (reg_addr == REG_STATUS);
   wire wr_mask = reg_wr && (reg_addr == REG_MASK);
   wire [ST_W-1:0] w1c = wr_status ? reg_wdata[ST_W-1:0] : '0;
   wire [ST_W-1:0] ev;
   assign ev[ST_REJECT] = priv_bad;
   assign ev[ST_DSI] = dsi_cmd;
   assign ev[ST_FLUSH] = wb_finish || flush_now;
   assign ev[ST_NEXTALL] = next_all;

   // read mux; unmapped addresses read zero
   logic [DATA_W-1:0] rd_mux;
   always_comb begin
      if (reg_addr == REG_CTRL) begin
         rd_mux = {{(DATA_W-CTRL_W){1'b0}}, ctrl_ff};
      end else if (reg_addr == REG_STATUS) begin
         rd_mux = {{(DATA_W-ST_W){1'b0}}, status_ff};
      end else if (reg_addr == REG_MASK) begin
         rd_mux = {{(DATA_W-ST_W){1'b0}}, mask_ff};
      end else if (reg_addr == REG_BUFST) begin
         rd_mux = {{(DATA_W-NBUF-1){1'b0}}, busy_ff, d_ff};
      end else begin
         rd_mux = '0;
      end
   end

   // next flag values; hardware sets win over clears, except that an internal-error drop clears every next flag
   always_comb begin
      nxt_d = (d_ff & ~flush_m) | dirty_m;
      nxt_b = (b_ff & ~flush_m) | fill_m;
      nxt_i = (i_ff & ~(op_m | fill_m)) | flush_m | inval_m;
      if (next_all) begin
         nxt_n = '0;
      end else begin
         nxt_n = (next_flags_ff & ~(flush_m | next_m)) | pref_m;
      end
      nxt_status = (status_ff & ~w1c) | ev;
   end

   // write-back sequencer
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         IOBFI_IDLE: begin
            if (flush_dirty) begin
               nxt_state = IOBFI_WB;
            end
         end
         IOBFI_WB: begin
            if (wb_done) begin
               nxt_state = IOBFI_IDLE;
            end
         end
         default: nxt_state = IOBFI_IDLE;
      endcase
   end

   // state, busy and write-back request
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_ff <= IOBFI_IDLE;
         busy_ff <= 1'b0;
         wb_req_ff <= 1'b0;
         wb_idx_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         busy_ff <= (nxt_state == IOBFI_WB);
         wb_req_ff <= (nxt_state == IOBFI_WB);
         if (flush_dirty) begin
            wb_idx_ff <= cmd_buf;
         end
      end
   end

   // buffer flags
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         d_ff <= FLAGS_RST;
         b_ff <= FLAGS_RST;
         i_ff <= INVAL_RST;
         next_flags_ff <= FLAGS_RST;
      end else begin
         d_ff <= nxt_d;
         b_ff <= nxt_b;
         i_ff <= nxt_i;
         next_flags_ff <= nxt_n;
      end
   end

   // command answer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rsp_valid_ff <= 1'b0;
         rsp_dsi_ff <= 1'b0;
         rsp_rdata_ff <= '0;
         inv_op_ff <= 1'b0;
      end else begin
         rsp_valid_ff <= rsp_now;
         rsp_dsi_ff <= dsi_cmd;
         rsp_rdata_ff <= load_word;
         inv_op_ff <= priv_bad;
      end
   end

   // refetch request toward the data path
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         refetch_ff <= 1'b0;
         reload_bcr4_ff <= 1'b0;
         refetch_idx_ff <= '0;
      end else begin
         refetch_ff <= op_refetch;
         reload_bcr4_ff <= op_refetch && op_is_bm;
         refetch_idx_ff <= op_idx;
      end
   end

   // software registers and interrupt
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_ff <= CTRL_RST;
         mask_ff <= MASK_RST;
         status_ff <= STATUS_RST;
         reg_rdata_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= reg_wdata[CTRL_W-1:0];
         end
         if (wr_mask) begin
            mask_ff <= reg_wdata[ST_W-1:0];
         end
         status_ff <= nxt_status;
         reg_rdata_ff <= reg_rd ? rd_mux : '0;
         irq_ff <= |(nxt_status & mask_ff);
      end
   end

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   priv_reject_a: assert property (
      priv_bad |=> rsp_valid_ff && rsp_dsi_ff && inv_op_ff)
      else $error("privileged command not rejected");

   priv_no_change_a: assert property (
      priv_bad |=> !wb_req_ff && !busy_ff && (rsp_rdata_ff == '0))
      else $error("rejected command started work");

   flush_wb_start_a: assert property (
      flush_dirty |=> wb_req_ff && busy_ff && !rsp_valid_ff)
      else $error("dirty flush did not start write-back");

   clean_flush_a: assert property (
      flush_now |=> !wb_req_ff && rsp_valid_ff && i_ff[$past(cmd_buf)])
      else $error("clean flush mishandled");

   busy_hold_a: assert property (
      busy_ff && !wb_done |=> busy_ff && !rsp_valid_ff)
      else $error("busy dropped before write-back end");

   wb_end_a: assert property (
      wb_finish |=> rsp_valid_ff && !busy_ff && i_ff[$past(wb_idx_ff)])
      else $error("write-back end not answered");

   flush_load_a: assert property (
      flush_ld |=> rsp_valid_ff && rsp_dsi_ff)
      else $error("flush load gave no storage interrupt");

   unbuf_inval_a: assert property (
      ok && is_inval && !buffered |=>
         rsp_valid_ff && !rsp_dsi_ff && (rsp_rdata_ff == '0))
      else $error("unbuffered invalidate not a nop");

   next_dsi_a: assert property (
      ok && is_next && (!buffered || !dual) |=> rsp_dsi_ff)
      else $error("next invalidate without support accepted");

   next_all_a: assert property (
      next_all |=> (next_flags_ff == '0) && !rsp_dsi_ff)
      else $error("internal error did not drop all next buffers");

   bm_reload_a: assert property (
      op_refetch && op_is_bm |=> refetch_ff && reload_bcr4_ff
         ##1 !reload_bcr4_ff || ($past(op_refetch) && $past(op_is_bm)))
      else $error("bus-master refetch missing control reload");

   // answers are only looked at in the cycle in which they stand
   unbuf_flush_a: assert property (
      ok && is_flush && !buffered |=>
         rsp_valid_ff && !rsp_dsi_ff && !wb_req_ff)
      else $error("unbuffered flush not a nop");

   flush_sel_a: assert property (
      flush_dirty |=> wb_idx_ff == $past(cmd_buf))
      else $error("write-back aimed at wrong buffer");

   dsi_with_rsp_a: assert property (
      rsp_dsi_ff |-> rsp_valid_ff)
      else $error("storage interrupt without an answer");

   // data path events kept out, their own clears are legal
   inval_load_a: assert property (
      inval_ld && !op_start && !fill_valid |=>
         rsp_valid_ff && !rsp_dsi_ff && (i_ff == $past(i_ff)))
      else $error("invalidate load changed the buffer");

   inval_set_a: assert property (
      inval_st |=> i_ff[$past(cmd_buf)])
      else $error("invalidate store did not set invalidate");

   priv_status_a: assert property (
      priv_bad |=> status_ff[ST_REJECT] && status_ff[ST_DSI])
      else $error("rejected command left no status");

   next_load_a: assert property (
      ok && is_next && !cmd_store |=> rsp_valid_ff && rsp_dsi_ff)
      else $error("next invalidate load gave no interrupt");

   // a prefetch in the same cycle may legally set the flag again
   next_clear_a: assert property (
      next_ok && !next_err && !prefetch_valid |=>
         rsp_valid_ff && !rsp_dsi_ff && !next_flags_ff[$past(cmd_buf)])
      else $error("next invalidate left the next flag set");

   no_readahead_a: assert property (
      !dual |=> (next_flags_ff & ~$past(next_flags_ff)) == '0)
      else $error("read-ahead without the dual option");

endmodule

// [dv/iobfi_mem_model.sv]
`timescale 1ns/100ps
// memory side of the write-back port, answers after lat cycles
module iobfi_mem_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // write-back handshake
   input wire logic wb_req_ff,
   input wire logic [3:0] lat,
   output logic wb_done
);
   // one pulse per request; waits past the request's last cycle so a
   // request still standing in the done cycle is not answered twice
   initial begin
      wb_done = 1'h0;
      forever begin
         @(posedge clk_sys);
         if (wb_req_ff === 1'h1 && !rst) begin
            repeat (lat) @(posedge clk_sys);
            wb_done <= 1'h1;
            @(posedge clk_sys);
            wb_done <= 1'h0;
            @(posedge clk_sys);
         end
      end
   end
endmodule

// [dv/iobfi_core_tb.sv]
`timescale 1ns/100ps
`define CK(n,e,g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", n, e, g); end end
module iobfi_core_tb;
   import iobfi_pkg::*;
   logic clk_sys = 1'h0, rst = 1'h1, cmd_valid = 1'h0, cmd_store = 1'h0;
   logic cmd_priv_key = 1'h0, next_err = 1'h0, fill_valid = 1'h0;
   logic fill_dirty = 1'h0, prefetch_valid = 1'h0, op_start = 1'h0;
   logic op_is_bm = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic [31:0] cmd_ea = 32'h0, cmd_wdata = 32'h0, reg_wdata = 32'h0;
   logic [3:0] fill_idx = 4'h0, prefetch_idx = 4'h0, op_idx = 4'h0;
   logic [3:0] reg_addr = 4'h0, lat = 4'h6, wb_idx_ff, refetch_idx_ff, b;
   logic busy_ff, rsp_valid_ff, rsp_dsi_ff, inv_op_ff, wb_req_ff, wb_done;
   logic refetch_ff, reload_bcr4_ff, irq_ff, dd;
   logic [31:0] rsp_rdata_ff, reg_rdata_ff;
   logic [15:0] next_flags_ff, d_exp;
   int mismatches = 0, samples_checked = 0, n;
   integer seed = 32'h403dbd24;

   iobfi_core i_iobfi_core (.clk_sys, .rst, .cmd_valid, .cmd_store, .cmd_ea,
      .cmd_wdata, .cmd_priv_key, .next_err, .busy_ff, .rsp_valid_ff,
      .rsp_dsi_ff, .rsp_rdata_ff, .inv_op_ff, .wb_req_ff, .wb_idx_ff,
      .wb_done, .fill_valid, .fill_dirty, .fill_idx, .prefetch_valid,
      .prefetch_idx, .op_start, .op_is_bm, .op_idx, .refetch_ff,
      .reload_bcr4_ff, .refetch_idx_ff, .next_flags_ff, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .irq_ff);
   iobfi_mem_model i_iobfi_mem_model (.clk_sys, .rst, .wb_req_ff, .lat,
      .wb_done);

   always #12.5 clk_sys = ~clk_sys;

   task results;
      if (mismatches == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // one command cycle; outputs sampled just after the taking edge
   task cmd(input logic st, input logic [7:0] c, input logic [3:0] bf,
            input logic [31:0] wd, input logic key, input logic er);
      @(posedge clk_sys);
      cmd_valid <= 1'h1;
      cmd_store <= st;
      cmd_ea <= {12'h000, bf, 8'h00, c};
      cmd_wdata <= wd;
      cmd_priv_key <= key;
      next_err <= er;
      @(posedge clk_sys);
      cmd_valid <= 1'h0;
      cmd_priv_key <= 1'h0;
      #1;
   endtask

   // k: 0 fill, 1 prefetch, 2 operation start
   task ev(input int k, input logic [3:0] i, input logic x);
      @(posedge clk_sys);
      fill_valid <= (k == 0);
      prefetch_valid <= (k == 1);
      op_start <= (k == 2);
      fill_idx <= i;
      prefetch_idx <= i;
      op_idx <= i;
      fill_dirty <= x;
      op_is_bm <= x;
      @(posedge clk_sys);
      fill_valid <= 1'h0;
      prefetch_valid <= 1'h0;
      op_start <= 1'h0;
      #1;
   endtask

   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask

   task rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1;
      `CK("reg_rdata", e, reg_rdata_ff)
   endtask

   // bounded wait; a slow memory must still answer well inside 40 cycles
   task wait_rsp;
      n = 0;
      while (rsp_valid_ff !== 1'h1 && n < 40) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      `CK("rsp_valid", 1'h1, rsp_valid_ff)
      `CK("busy", 1'h0, busy_ff)
   endtask

   initial begin
      repeat (4000) @(posedge clk_sys);
      mismatches++;
      results();
   end

   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'h0;
      rd(REG_CTRL, 32'h0);
      rd(REG_STATUS, 32'h0);
      rd(REG_MASK, 32'h0);
      // unbuffered after reset
      cmd(1'h1, CMD_FLUSH, 4'h3, 32'h0, 1'h0, 1'h0);
      `CK("wb_req", 1'h0, wb_req_ff)
      cmd(1'h0, CMD_FLUSH, 4'h3, 32'h0, 1'h0, 1'h0);
      `CK("dsi", 1'h0, rsp_dsi_ff)
      cmd(1'h0, CMD_INVAL, 4'h3, 32'h0, 1'h0, 1'h0);
      `CK("inv_ld", 32'h0, rsp_rdata_ff)
      cmd(1'h1, CMD_NEXT, 4'h3, 32'h0, 1'h0, 1'h0);
      `CK("dsi", 1'h1, rsp_dsi_ff)
      // buffered, single buffer
      wr(REG_CTRL, 32'h1);
      ev(1, 4'h5, 1'h0);
      `CK("next_flags", 16'h0, next_flags_ff)
      cmd(1'h1, CMD_NEXT, 4'h5, 32'h0, 1'h0, 1'h0);
      `CK("dsi", 1'h1, rsp_dsi_ff)
      ev(0, 4'h3, 1'h1);
      cmd(1'h0, CMD_INVAL, 4'h3, 32'h0, 1'h0, 1'h0);
      `CK("inv_ld", 32'hc000_0000, rsp_rdata_ff)
      cmd(1'h0, CMD_INVAL, 4'h3, 32'h0, 1'h0, 1'h0);
      `CK("inv_ld", 32'hc000_0000, rsp_rdata_ff)
      cmd(1'h0, CMD_FLUSH, 4'h3, 32'h0, 1'h0, 1'h0);
      `CK("dsi", 1'h1, rsp_dsi_ff)
      cmd(1'h1, CMD_FLUSH, 4'h3, 32'h0, 1'h1, 1'h0);
      `CK("inv_op", 1'h1, inv_op_ff)
      `CK("dsi", 1'h1, rsp_dsi_ff)
      `CK("wb_req", 1'h0, wb_req_ff)
      cmd(1'h0, CMD_INVAL, 4'h3, 32'h0, 1'h0, 1'h0);
      `CK("inv_ld", 32'hc000_0000, rsp_rdata_ff)
      // dirty flush with junk data, then a command while busy
      cmd(1'h1, CMD_FLUSH, 4'h3, 32'hffff_ffff, 1'h0, 1'h0);
      `CK("wb_idx", 4'h3, wb_idx_ff)
      `CK("busy", 1'h1, busy_ff)
      cmd(1'h0, CMD_INVAL, 4'h3, 32'h0, 1'h0, 1'h0);
      `CK("rsp_valid", 1'h0, rsp_valid_ff)
      wait_rsp();
      cmd(1'h0, CMD_INVAL, 4'h3, 32'h0, 1'h0, 1'h0);
      `CK("inv_ld", 32'h2000_0000, rsp_rdata_ff)
      cmd(1'h1, CMD_FLUSH, 4'h3, 32'h0, 1'h0, 1'h0);
      `CK("wb_req", 1'h0, wb_req_ff)
      // random buffers, dirtiness and memory latency
      d_exp = 16'h0;
      for (int i = 0; i < 8; i++) begin
         b = 4'($random(seed));
         dd = 1'($random(seed));
         lat <= 4'($random(seed));
         ev(0, b, dd);
         d_exp[b] = d_exp[b] | dd;
         cmd(1'h0, CMD_INVAL, b, 32'h0, 1'h0, 1'h0);
         `CK("state", {d_exp[b], 3'h4, 28'h0}, rsp_rdata_ff)
         rd(REG_BUFST, {16'h0, d_exp});
         cmd(1'h1, CMD_FLUSH, b, $random(seed), 1'h0, 1'h0);
         `CK("wb_req", d_exp[b], wb_req_ff)
         if (d_exp[b]) `CK("wb_idx", b, wb_idx_ff)
         wait_rsp();
         d_exp[b] = 1'h0;
      end
      // refetch after invalidate
      ev(0, 4'h2, 1'h0);
      ev(2, 4'h2, 1'h0);
      `CK("refetch", 1'h0, refetch_ff)
      cmd(1'h1, CMD_INVAL, 4'h2, INVAL_DATA, 1'h0, 1'h0);
      ev(2, 4'h2, 1'h1);
      `CK("refetch", 1'h1, refetch_ff)
      `CK("reload", 1'h1, reload_bcr4_ff)
      `CK("ref_idx", 4'h2, refetch_idx_ff)
      cmd(1'h1, CMD_INVAL, 4'h2, INVAL_DATA, 1'h0, 1'h0);
      ev(2, 4'h2, 1'h0);
      `CK("reload", 1'h0, reload_bcr4_ff)
      // dual buffering: prefetch and discard
      wr(REG_CTRL, 32'h3);
      ev(1, 4'h5, 1'h0);
      ev(1, 4'h9, 1'h0);
      `CK("next_flags", 16'h0220, next_flags_ff)
      cmd(1'h1, CMD_NEXT, 4'h5, 32'h0, 1'h0, 1'h0);
      `CK("dsi", 1'h0, rsp_dsi_ff)
      `CK("next_flags", 16'h0200, next_flags_ff)
      cmd(1'h0, CMD_NEXT, 4'h9, 32'h0, 1'h0, 1'h0);
      `CK("dsi", 1'h1, rsp_dsi_ff)
      wr(REG_STATUS, 32'hf);
      rd(REG_STATUS, 32'h0);
      cmd(1'h1, CMD_NEXT, 4'h1, 32'h0, 1'h0, 1'h1);
      `CK("next_flags", 16'h0, next_flags_ff)
      `CK("dsi", 1'h0, rsp_dsi_ff)
      rd(REG_STATUS, 32'h8);
      `CK("irq", 1'h0, irq_ff)
      wr(REG_MASK, 32'h8);
      rd(REG_MASK, 32'h8);
      `CK("irq", 1'h1, irq_ff)
      wr(REG_STATUS, 32'h8);
      rd(REG_STATUS, 32'h0);
      `CK("irq", 1'h0, irq_ff)
      // unmapped place reads zero and ignores writes
      wr(4'h2, 32'hffff_ffff);
      rd(4'h2, 32'h0);
      rd(REG_CTRL, 32'h3);
      results();
   end
endmodule
